// ===== logic/pcci_top.sv
// program control command interpreter with program memory and status
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module pcci_top #(
   parameter int          MEM_DEPTH = 256,
   parameter logic [31:0] VER_STR   = 32'h3130_3131,
   parameter logic [31:0] VER_BIN   = 32'h0000_0101
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              cmd_valid,
   input  wire pcci_pkg::pcci_cmd_t cmd,
   output      pcci_pkg::pcci_rsp_t rsp,
   output      logic              fwd_valid,
   output      pcci_pkg::pcci_cmd_t fwd_cmd,
   output      logic              prog_run,
   output      logic [15:0]       prog_pc,
   input  wire logic              exec_done,
   input  wire logic              exec_wait,
   input  wire logic [7:0]        flag_set,
   output      logic              restore_req,
   output      logic              cpu_restart,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      logic [31:0]       reg_rdata
);
   localparam int AW = $clog2(MEM_DEPTH);

   // elaboration-time refusal of depths the pointer logic cannot serve
   if (MEM_DEPTH < 2 || MEM_DEPTH > 65536 ||
       (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("MEM_DEPTH must be a power of two, 2 to 65536");
   end

   typedef struct packed {
      pcci_pkg::pcci_run_t run;
      logic                runf;
      logic                dl;
      logic                waitf;
      logic [15:0]         mptr;
      logic [15:0]         pc;
      logic [7:0]          sp;
      logic [31:0]         accu;
      logic [31:0]         xreg;
      logic [7:0]          flags;
      pcci_pkg::pcci_rsp_t rsp;
      logic                fwd_valid;
      pcci_pkg::pcci_cmd_t fwd_cmd;
      logic                restore;
      logic                restart;
      logic [31:0]         rdata;
   } pcci_state_t;

   pcci_state_t              st;
   pcci_state_t              next_st;
   logic [55:0]              mem [MEM_DEPTH];
   logic                     mem_we;
   logic [AW-1:0]            mem_wa;
   logic [55:0]              mem_rd;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [7:0] mode_code(input pcci_state_t s);
      if (s.dl)
         mode_code = pcci_pkg::MODE_DL;
      else if (s.run == pcci_pkg::RUN_GO)
         mode_code = pcci_pkg::MODE_RUN;
      else if (s.run == pcci_pkg::RUN_STEP)
         mode_code = pcci_pkg::MODE_STEP;
      else
         mode_code = pcci_pkg::MODE_STOP;
   endfunction : mode_code

   function automatic logic is_ctrl(input logic [7:0] op);
      is_ctrl = (op >= pcci_pkg::OP_STOP && op <= pcci_pkg::OP_FACTORY) ||
                op == pcci_pkg::OP_RESTART;
   endfunction : is_ctrl

   assign mem_rd = mem[cmd.value[AW-1:0]];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_st           = st;
      next_st.rsp       = '0;
      next_st.fwd_valid = 1'b0;
      next_st.restore   = 1'b0;
      next_st.restart   = 1'b0;
      next_st.rdata     = '0;
      next_st.waitf     = exec_wait;
      mem_we            = 1'b0;
      mem_wa            = st.mptr[AW-1:0];

      // stored program progress
      if (exec_done && st.run != pcci_pkg::RUN_STOP) begin
         next_st.pc = st.pc + 16'h0001;
         if (st.run == pcci_pkg::RUN_STEP)
            next_st.run = pcci_pkg::RUN_STOP;
      end

      // register bus
      if (reg_wr) begin
         if (reg_addr == pcci_pkg::REG_ACCU)
            next_st.accu = reg_wdata;
         else if (reg_addr == pcci_pkg::REG_XREG)
            next_st.xreg = reg_wdata;
         else if (reg_addr == pcci_pkg::REG_FLAGS)
            next_st.flags = st.flags & ~reg_wdata[7:0];
      end
      if (reg_rd) begin
         if (reg_addr == pcci_pkg::REG_STATUS)
            next_st.rdata = {mode_code(st), 7'h00, st.waitf, st.mptr};
         else if (reg_addr == pcci_pkg::REG_PC)
            next_st.rdata = {16'h0000, st.pc};
         else if (reg_addr == pcci_pkg::REG_ACCU)
            next_st.rdata = st.accu;
         else if (reg_addr == pcci_pkg::REG_XREG)
            next_st.rdata = st.xreg;
         else if (reg_addr == pcci_pkg::REG_FLAGS)
            next_st.rdata = {24'h000000, st.flags};
      end

      // commands; stored-program sources are never taken here
      if (cmd_valid && cmd.direct) begin
         if (!is_ctrl(cmd.opcode)) begin
            if (st.dl) begin
               mem_we           = 1'b1;
               next_st.mptr     = st.mptr + 16'h0001;
               next_st.rsp      = '{1'b1, pcci_pkg::ST_OK, cmd.opcode,
                                    24'h000000, cmd.value};
            end else begin
               next_st.fwd_valid = 1'b1;
               next_st.fwd_cmd   = cmd;
            end
         end else begin
            next_st.rsp.valid  = 1'b1;
            next_st.rsp.status = pcci_pkg::ST_OK;
            next_st.rsp.opcode = cmd.opcode;
            case (cmd.opcode)
               pcci_pkg::OP_STOP: begin
                  next_st.run = pcci_pkg::RUN_STOP;
               end
               pcci_pkg::OP_RUN: begin
                  if (cmd.ctype == 8'h00) begin
                     next_st.run = pcci_pkg::RUN_GO;
                  end else if (cmd.ctype == 8'h01) begin
                     next_st.run = pcci_pkg::RUN_GO;
                     next_st.pc  = cmd.value[15:0];
                  end else begin
                     next_st.rsp.status = pcci_pkg::ST_BAD_TYP;
                  end
               end
               pcci_pkg::OP_STEP: begin
                  next_st.run = pcci_pkg::RUN_STEP;
               end
               pcci_pkg::OP_RESET: begin
                  next_st.run   = pcci_pkg::RUN_STOP;
                  next_st.pc    = '0;
                  next_st.sp    = '0;
                  next_st.accu  = '0;
                  next_st.xreg  = '0;
                  next_st.flags = '0;
               end
               pcci_pkg::OP_DL_ON: begin
                  next_st.dl   = 1'b1;
                  next_st.mptr = cmd.value[15:0];
               end
               pcci_pkg::OP_DL_OFF: begin
                  next_st.dl = 1'b0;
               end
               pcci_pkg::OP_MEM_RD: begin
                  next_st.rsp.ext   = mem_rd[55:32];
                  next_st.rsp.value = mem_rd[31:0];
               end
               pcci_pkg::OP_STATUS: begin
                  if (cmd.ctype == 8'h00)
                     next_st.rsp.value = {mode_code(st), 7'h00,
                                          st.waitf, st.mptr};
                  else if (cmd.ctype == 8'h01)
                     next_st.rsp.value = {mode_code(st), 7'h00,
                                          st.waitf, st.pc};
                  else if (cmd.ctype == 8'h02)
                     next_st.rsp.value = st.accu;
                  else if (cmd.ctype == 8'h03)
                     next_st.rsp.value = st.xreg;
                  else
                     next_st.rsp.status = pcci_pkg::ST_BAD_TYP;
               end
               pcci_pkg::OP_VERSION: begin
                  if (cmd.ctype == 8'h00)
                     next_st.rsp.value = VER_STR;
                  else if (cmd.ctype == 8'h01)
                     next_st.rsp.value = VER_BIN;
                  else
                     next_st.rsp.status = pcci_pkg::ST_BAD_TYP;
               end
               pcci_pkg::OP_FACTORY: begin
                  if (cmd.value == pcci_pkg::KEY_VALUE) begin
                     next_st.rsp.valid = 1'b0;
                     next_st.restore   = 1'b1;
                  end else begin
                     next_st.rsp.status = pcci_pkg::ST_BAD_VAL;
                  end
               end
               default: begin
                  if (cmd.value == pcci_pkg::KEY_VALUE) begin
                     next_st.restart = 1'b1;
                     next_st.run     = pcci_pkg::RUN_STOP;
                     next_st.dl      = 1'b0;
                     next_st.pc      = '0;
                     next_st.sp      = '0;
                     next_st.accu    = '0;
                     next_st.xreg    = '0;
                     next_st.flags   = '0;
                     next_st.mptr    = '0;
                  end else begin
                     next_st.rsp.status = pcci_pkg::ST_BAD_VAL;
                  end
               end
            endcase
         end
      end

      // a flag event in the clearing cycle survives
      next_st.flags = next_st.flags | flag_set;
      // run level kept in its own flop so the pin comes from a register
      next_st.runf  = (next_st.run != pcci_pkg::RUN_STOP);
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (srst)
         st <= '0;
      else
         st <= next_st;
   end

   always_ff @(posedge clk) begin
      if (mem_we)
         mem[mem_wa] <= {cmd.opcode, cmd.ctype, cmd.bank, cmd.value};
   end

   assign rsp         = st.rsp;
   assign fwd_valid   = st.fwd_valid;
   assign fwd_cmd     = st.fwd_cmd;
   assign prog_run    = st.runf;
   assign prog_pc     = st.pc;
   assign restore_req = st.restore;
   assign cpu_restart = st.restart;
   assign reg_rdata   = st.rdata;
endmodule : pcci_top

// ===== logic/pcci_pkg.sv
// constants and carriers for the program control command interpreter
package pcci_pkg;
   localparam logic [7:0]  OP_STOP    = 8'h80;
   localparam logic [7:0]  OP_RUN     = 8'h81;
   localparam logic [7:0]  OP_STEP    = 8'h82;
   localparam logic [7:0]  OP_RESET   = 8'h83;
   localparam logic [7:0]  OP_DL_ON   = 8'h84;
   localparam logic [7:0]  OP_DL_OFF  = 8'h85;
   localparam logic [7:0]  OP_MEM_RD  = 8'h86;
   localparam logic [7:0]  OP_STATUS  = 8'h87;
   localparam logic [7:0]  OP_VERSION = 8'h88;
   localparam logic [7:0]  OP_FACTORY = 8'h89;
   localparam logic [7:0]  OP_RESTART = 8'hff;
   localparam logic [31:0] KEY_VALUE  = 32'h0000_04d2;
   localparam logic [7:0]  ST_OK      = 8'h64;
   localparam logic [7:0]  ST_BAD_TYP = 8'h03;
   localparam logic [7:0]  ST_BAD_VAL = 8'h04;
   localparam logic [7:0]  MODE_STOP  = 8'h00;
   localparam logic [7:0]  MODE_RUN   = 8'h01;
   localparam logic [7:0]  MODE_STEP  = 8'h02;
   localparam logic [7:0]  MODE_DL    = 8'h03;
   localparam logic [7:0]  REG_STATUS = 8'h00;
   localparam logic [7:0]  REG_PC     = 8'h04;
   localparam logic [7:0]  REG_ACCU   = 8'h08;
   localparam logic [7:0]  REG_XREG   = 8'h0c;
   localparam logic [7:0]  REG_FLAGS  = 8'h10;
   localparam int          PTR_W      = 16;

   typedef struct packed {
      logic        direct;
      logic [7:0]  opcode;
      logic [7:0]  ctype;
      logic [7:0]  bank;
      logic [31:0] value;
   } pcci_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  status;
      logic [7:0]  opcode;
      logic [23:0] ext;
      logic [31:0] value;
   } pcci_rsp_t;

   typedef enum logic [1:0] {
      RUN_STOP,
      RUN_GO,
      RUN_STEP
   } pcci_run_t;
endpackage : pcci_pkg

// ===== tb/pcci_host.sv
// host model that frames control commands for the interpreter
`timescale 1ns/1ps
module pcci_host (
   input  wire logic                clk,
   input  wire logic                req,
   input  wire pcci_pkg::pcci_cmd_t want,
   output      logic                cmd_valid,
   output      pcci_pkg::pcci_cmd_t cmd
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // idle frame bits toggle so stale values never look valid
   always @(posedge clk) begin
      cmd_valid <= req;
      if (req)
         cmd <= '{want.direct, want.opcode, want.ctype, 8'h00,
                  want.value};
      else
         cmd <= ~cmd;
   end
endmodule : pcci_host

// ===== tb/pcci_props.sv
// concurrent checks on the command port of the interpreter
`timescale 1ns/1ps
module pcci_props (
   input wire logic                clk,
   input wire logic                srst,
   input wire logic                cmd_valid,
   input wire pcci_pkg::pcci_cmd_t cmd,
   input wire pcci_pkg::pcci_rsp_t rsp,
   input wire logic                prog_run,
   input wire logic [15:0]         prog_pc,
   input wire logic                restore_req,
   input wire logic                cpu_restart
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic       tk;
   logic       key;
   logic [7:0] op;
   assign tk = cmd_valid && cmd.direct;
   assign key = cmd.value == pcci_pkg::KEY_VALUE;
   assign op = cmd.opcode;
   a_indirect_ignored: assert property (cmd_valid && !cmd.direct |=>
      !rsp.valid) else $error("indirect command answered");
   a_stop_halts: assert property (tk && op == pcci_pkg::OP_STOP |=>
      !prog_run) else $error("stop left program running");
   a_run_address: assert property (tk && op == pcci_pkg::OP_RUN &&
      cmd.ctype == 8'h01 |=> prog_run && prog_pc == $past(cmd.value[15:0]))
      else $error("run from address wrong");
   a_step_starts: assert property (tk && op == pcci_pkg::OP_STEP |=>
      prog_run) else $error("step did not start");
   a_reset_clears: assert property (tk && op == pcci_pkg::OP_RESET |=>
      !prog_run && prog_pc == 16'h0000) else $error("reset left state");
   a_factory_silent: assert property (tk && op == pcci_pkg::OP_FACTORY
      && key |=> restore_req && !rsp.valid) else $error("restore wrong");
   a_factory_key: assert property (tk && op == pcci_pkg::OP_FACTORY &&
      !key |=> !restore_req && rsp.status == pcci_pkg::ST_BAD_VAL)
      else $error("restore without key");
   a_restart_pulse: assert property (tk && op == pcci_pkg::OP_RESTART
      |=> cpu_restart == $past(key) && rsp.valid) else $error("restart wrong");
   a_reply_echo: assert property (tk && (op inside {[8'h80:8'h89], 8'hff}) &&
      !(op == pcci_pkg::OP_FACTORY && key) |=> rsp.valid &&
      rsp.opcode == $past(op)) else $error("reply missing or opcode wrong");
endmodule : pcci_props
bind pcci_top pcci_props u_props (.clk(clk), .srst(srst),
   .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .prog_run(prog_run),
   .prog_pc(prog_pc), .restore_req(restore_req), .cpu_restart(cpu_restart));

// ===== tb/tb_top.sv
// self-checking bench for the control command interpreter
`timescale 1ns/1ps
module tb_top;
   localparam logic [31:0] V_S = 32'h4142_4344; // arbitrary value
   localparam logic [31:0] V_B = 32'h0000_0203; // arbitrary value
   logic                clk, srst, req, exec_done, exec_wait, reg_wr, reg_rd;
   logic                cmd_valid, fwd_valid, prog_run, restore_req;
   logic                cpu_restart, g_fwd, g_rst, g_cpu;
   logic [7:0]          flag_set, reg_addr;
   logic [15:0]         prog_pc;
   logic [31:0]         reg_wdata, reg_rdata;
   pcci_pkg::pcci_cmd_t want, cmd, fwd_cmd;
   pcci_pkg::pcci_rsp_t rsp, got;
   int                  err_total, comparisons;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   pcci_host host (.clk(clk), .req(req), .want(want),
      .cmd_valid(cmd_valid), .cmd(cmd));
   pcci_top #(.VER_STR(V_S), .VER_BIN(V_B)) dut (.clk(clk), .srst(srst),
      .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .fwd_valid(fwd_valid),
      .fwd_cmd(fwd_cmd), .prog_run(prog_run), .prog_pc(prog_pc),
      .exec_done(exec_done), .exec_wait(exec_wait), .flag_set(flag_set),
      .restore_req(restore_req), .cpu_restart(cpu_restart),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   //*****************************************
   // shared tasks
   //*****************************************
   task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // reply and side pulses are captured in the cycle they stand
   task automatic tx(input logic [7:0] op, input logic [7:0] ty,
                     input logic [31:0] v, input logic dir);
      @(posedge clk);
      req <= 1'b1;
      want <= '{dir, op, ty, 8'h00, v};
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1;
      got = rsp;
      {g_fwd, g_rst, g_cpu} = {fwd_valid, restore_req, cpu_restart};
   endtask : tx
   task automatic ok(input logic [7:0] st, input logic [7:0] op);
      chk({got.valid, got.status, got.opcode}, {1'b1, st, op});
   endtask : ok
   task automatic pulse(input logic [7:0] f);
      @(posedge clk);
      exec_done <= ~|f;
      flag_set <= f;
      @(posedge clk);
      exec_done <= 1'b0;
      flag_set <= 8'h00;
      #1;
   endtask : pulse
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   //*****************************************
   // scenarios
   //*****************************************
   task automatic t_program;
      tx(pcci_pkg::OP_RUN, 8'h01, 32'h10, 1'b1);
      ok(pcci_pkg::ST_OK, pcci_pkg::OP_RUN);
      pulse(8'h00);
      chk({prog_run, prog_pc}, 17'h1_0011);
      tx(pcci_pkg::OP_STATUS, 8'h01, 32'h0, 1'b1);
      chk(got.value, {pcci_pkg::MODE_RUN, 8'h01, 16'h0011});
      tx(pcci_pkg::OP_STOP, 8'h00, 32'h0, 1'b1);
      pulse(8'h00);
      chk({prog_run, prog_pc}, 17'h0_0011);
      tx(pcci_pkg::OP_STEP, 8'h00, 32'h0, 1'b1);
      tx(pcci_pkg::OP_STATUS, 8'h01, 32'h0, 1'b1);
      chk(got.value, {pcci_pkg::MODE_STEP, 8'h01, 16'h0011});
      pulse(8'h00);
      chk({prog_run, prog_pc}, 17'h0_0012);
      tx(pcci_pkg::OP_RUN, 8'h02, 32'h0, 1'b1);
      ok(pcci_pkg::ST_BAD_TYP, pcci_pkg::OP_RUN);
      tx(pcci_pkg::OP_RUN, 8'h00, 32'h0, 1'b1);
      chk({prog_run, prog_pc}, 17'h1_0012);
   endtask : t_program
   task automatic t_clear;
      wr(pcci_pkg::REG_ACCU, 32'ha5a5_0001);
      wr(pcci_pkg::REG_XREG, 32'h777);
      tx(pcci_pkg::OP_STATUS, 8'h02, 32'h0, 1'b1);
      chk(got.value, 32'ha5a5_0001);
      tx(pcci_pkg::OP_STATUS, 8'h03, 32'h0, 1'b1);
      chk(got.value, 32'h777);
      tx(pcci_pkg::OP_STATUS, 8'h04, 32'h0, 1'b1);
      ok(pcci_pkg::ST_BAD_TYP, pcci_pkg::OP_STATUS);
      pulse(8'h04);
      rd(pcci_pkg::REG_FLAGS, 32'h4);
      tx(pcci_pkg::OP_RESET, 8'h00, 32'h0, 1'b1);
      chk({prog_run, prog_pc}, 17'h0);
      rd(pcci_pkg::REG_ACCU, 32'h0);
      rd(pcci_pkg::REG_XREG, 32'h0);
      rd(pcci_pkg::REG_FLAGS, 32'h0);
      rd(8'h40, 32'h0);
   endtask : t_clear
   task automatic t_download;
      tx(pcci_pkg::OP_DL_ON, 8'h00, 32'h5, 1'b1);
      tx(8'h05, 8'h02, 32'h1234, 1'b1);
      chk(g_fwd, 1'b0);
      tx(pcci_pkg::OP_STATUS, 8'h00, 32'h0, 1'b1);
      chk(got.value, {pcci_pkg::MODE_DL, 8'h01, 16'h0006});
      tx(pcci_pkg::OP_DL_OFF, 8'h00, 32'h0, 1'b1);
      tx(pcci_pkg::OP_MEM_RD, 8'h00, 32'h5, 1'b1);
      chk(got, {1'b1, pcci_pkg::ST_OK, 8'h86, 24'h050200, 32'h1234});
      tx(8'h05, 8'h02, 32'h99, 1'b1);
      chk({g_fwd, fwd_cmd.value}, {1'b1, 32'h99});
      tx(pcci_pkg::OP_STATUS, 8'h00, 32'h0, 1'b0);
      chk(got.valid, 1'b0);
   endtask : t_download
   task automatic t_replies;
      tx(pcci_pkg::OP_VERSION, 8'h00, 32'h0, 1'b1);
      chk(got.value, V_S);
      tx(pcci_pkg::OP_VERSION, 8'h01, 32'h0, 1'b1);
      chk(got.value, V_B);
      tx(pcci_pkg::OP_FACTORY, 8'h00, pcci_pkg::KEY_VALUE, 1'b1);
      chk({got.valid, g_rst}, 2'b01);
      tx(pcci_pkg::OP_FACTORY, 8'h00, 32'h0000_04d1, 1'b1);
      chk({got.status, g_rst}, {pcci_pkg::ST_BAD_VAL, 1'b0});
      tx(pcci_pkg::OP_RESTART, 8'h00, 32'h0000_04d3, 1'b1);
      chk({got.status, g_cpu}, {pcci_pkg::ST_BAD_VAL, 1'b0});
      tx(pcci_pkg::OP_RESTART, 8'h00, pcci_pkg::KEY_VALUE, 1'b1);
      chk({got.status, g_cpu, prog_run}, {pcci_pkg::ST_OK, 2'b10});
   endtask : t_replies
   initial begin
      {srst, req, exec_done, exec_wait, reg_wr, reg_rd} = 6'b100000;
      {flag_set, reg_addr, reg_wdata} = '0;
      want = '0;
      err_total = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      exec_wait <= 1'b1;
      t_program();
      t_clear();
      t_download();
      t_replies();
      give_verdict();
   end
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
endmodule : tb_top
